// >>> tb/jdrp_host_model.sv
`timescale 1ns/1ps
// Debugger host on the scan pins; tck stands low between frames
module jdrp_host_model (
	input wire logic i_clk_sys,
	input wire logic i_tdo,
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	output logic o_trst_n
);
	// Idle pin levels
	initial
	begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
		o_trst_n = 1'b1;
	end

	// One 164 ns tck period, tdo taken just before the rising edge
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
	begin
		@(posedge i_clk_sys);
		o_tms <= tms;
		o_tdi <= tdi;
		repeat (20) @(posedge i_clk_sys);
		tdo = i_tdo;
		o_tck <= 1'b1;
		repeat (20) @(posedge i_clk_sys);
		o_tck <= 1'b0;
	end
	endtask

	// Instruction or 36-bit data scan, LSB first
	task automatic scan(input bit ir, input int n, input logic [35:0] din,
		output logic [35:0] dout);
		logic b;
	begin
		dout = '0;
		// Leave test-logic-reset first; from idle this tick changes nothing
		tick(1'b0, ~o_tdi, b);
		tick(1'b1, ~o_tdi, b);
		if (ir)
			tick(1'b1, ~o_tdi, b);
		tick(1'b0, ~o_tdi, b);
		tick(1'b0, ~o_tdi, b);
		for (int i = 0; i < n; i++)
		begin
			tick(i == n - 1, din[i], b);
			dout[i] = b;
		end
		tick(1'b1, ~o_tdi, b);
		tick(1'b0, ~o_tdi, b);
	end
	endtask

	// Pulse the test reset pin low for 40 system clocks, 160 ns
	task automatic test_reset();
	begin
		@(posedge i_clk_sys);
		o_trst_n <= 1'b0;
		repeat (40) @(posedge i_clk_sys);
		o_trst_n <= 1'b1;
		repeat (10) @(posedge i_clk_sys);
	end
	endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin \
		check_count++; \
		if ((got) !== (ex)) \
		begin \
			num_errors++; \
			$display("Error %s expected %h seen %h", nm, ex, got); \
		end \
	end
module tb_top;
	typedef struct {
		logic v;
		logic [31:0] word;
		logic fl;
		logic lp;
		logic rd;
		logic cap;
		logic rdy;
		logic ovf;
	} jdrp_tb_row_s;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic tck, tms, tdi, trst_n, tdo, tdo_oe, wr, rd, irq;
	logic [jdrp_pkg::ADDR_W-1:0] addr;
	logic [jdrp_pkg::WORD_W-1:0] wdata, rdata, val, exp_buf;
	logic [35:0] dout;
	int num_errors = 0;
	int check_count = 0;
	// Back-to-back valid scans, polls, flush with and without data
	jdrp_tb_row_s rows [5] = '{
		'{1'b1, 32'ha5a5_0001, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0},
		'{1'b1, 32'h5a5a_0002, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
		'{1'b0, 32'hdead_beef, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
		'{1'b1, 32'hffff_ffff, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1},
		'{1'b0, 32'h0000_0000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1}};

	// System clock, 4 ns
	always #2 clk_sys = ~clk_sys;

	jdrp_rx_path u_jdrp_rx_path (
		.i_clk_sys(clk_sys), .i_srst(srst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
		.i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
	jdrp_host_model u_jdrp_host_model (
		.i_clk_sys(clk_sys), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
		.o_trst_n(trst_n));

	// Handler register bus
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
	begin
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		@(posedge clk_sys);
		#1;
	end
	endtask
	task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
	begin
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	end
	endtask

	// Verdict and end of run
	task automatic results();
	begin
		$display("Checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask

	// Watchdog
	initial
	begin
		repeat (80000) @(posedge clk_sys);
		num_errors++;
		results();
	end

	// Main sequence
	initial
	begin
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		exp_buf = '0;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		u_jdrp_host_model.scan(1'b0, 36, 36'h8_0000_0000, dout);
		bus_rd(jdrp_pkg::ADDR_CTRL, val);
		`CHK("bypass ready", 1'b0, val[31])
		u_jdrp_host_model.scan(1'b1, 5, 36'h02, dout);
		`CHK("ir capture", 5'h01, dout[4:0])
		`CHK("tdo released", 1'b0, tdo_oe)
		for (int i = 0; i < 5; i++)
		begin
			u_jdrp_host_model.scan(1'b0, 36,
				{rows[i].v, rows[i].word, rows[i].fl, rows[i].lp, 1'b0}, dout);
			if (rows[i].v)
				exp_buf = rows[i].word;
			`CHK("captured", {35'h0, rows[i].cap}, dout)
			bus_rd(jdrp_pkg::ADDR_CTRL, val);
			`CHK("ready", rows[i].rdy, val[31])
			`CHK("overflow", rows[i].ovf, val[30])
			`CHK("loop flag", rows[i].lp, val[29])
			if (rows[i].rd)
			begin
				bus_rd(jdrp_pkg::ADDR_RXBUF, val);
				`CHK("rx word", exp_buf, val)
			end
		end
		@(posedge clk_sys);
		#1;
		`CHK("rdata idle", 32'h0, rdata)
		bus_rd(jdrp_pkg::ADDR_IRQ_STAT, val);
		`CHK("status", 3'h7, val[2:0])
		`CHK("irq masked", 1'b0, irq)
		bus_wr(jdrp_pkg::ADDR_IRQ_MASK, 32'h1);
		`CHK("irq on", 1'b1, irq)
		bus_wr(jdrp_pkg::ADDR_IRQ_STAT, 32'h7);
		`CHK("irq cleared", 1'b0, irq)
		bus_wr(jdrp_pkg::ADDR_CTRL, 32'h4000_0000);
		bus_wr(4'h2, 32'hffff_ffff);
		bus_rd(4'h2, val);
		`CHK("unmapped", 32'h0, val)
		// Test reset keeps the handshake and returns the scan port to bypass
		u_jdrp_host_model.test_reset();
		bus_rd(jdrp_pkg::ADDR_CTRL, val);
		`CHK("ctrl after trst", 3'h0, val[31:29])
		u_jdrp_host_model.scan(1'b0, 36, 36'h8_0000_0002, dout);
		bus_rd(jdrp_pkg::ADDR_CTRL, val);
		`CHK("trst ir reset", 3'h0, val[31:29])
		// Processor reset mid-run
		u_jdrp_host_model.scan(1'b1, 5, 36'h02, dout);
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		u_jdrp_host_model.scan(1'b1, 5, 36'h02, dout);
		u_jdrp_host_model.scan(1'b0, 36, 36'h8_0000_0002, dout);
		`CHK("srst capture", 36'h0, dout)
		bus_rd(jdrp_pkg::ADDR_CTRL, val);
		`CHK("write after srst", 3'h5, val[31:29])
		results();
	end
endmodule

// >>> verilog/jdrp_pkg.sv
// Summary of operation
// - Capture loads receive-ready into scan bit 0
// - Shift moves scan bits out while in
// - Update copies scan 35:1 into holding
// - Only new valid data reaches receive buffer
// - Write logic clears valid after each use
// - Buffer write sets handshake ready bit 31
// - Write over unread data sets overflow 30
// - Valid update writes word 34:3 to buffer
// - Flush and loop flag ignore valid
// - Loop flag copied into handshake bit 29
// - Flush request clears handshake bit 31
// - Test reset clears holding bits 0,1,34
// - Processor reset leaves holding register alone
// - Instruction 00010 selects receive path
// - Shared 36-bit scan shift register
package jdrp_pkg;

	// ----------------------------------------------------------------
	// Scan path geometry
	// ----------------------------------------------------------------
	localparam int SR_W = 36;
	localparam int HOLD_W = 35;
	localparam int WORD_W = 32;
	localparam int IR_W = 5;
	localparam logic [IR_W-1:0] IR_RX_SELECT = 5'h02;
	localparam logic [IR_W-1:0] IR_RESET_VAL = 5'h1f;
	localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 5'h01;

	// Holding register fields
	localparam int HOLD_VALID = 34;
	localparam int HOLD_WORD_HI = 33;
	localparam int HOLD_WORD_LO = 2;
	localparam int HOLD_FLUSH = 1;
	localparam int HOLD_LOOP = 0;

	// Handshake control bits
	localparam int CTRL_RDY = 31;
	localparam int CTRL_OVF = 30;
	localparam int CTRL_LOOP = 29;

	// ----------------------------------------------------------------
	// Handler register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RXBUF = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'hc;

	// Interrupt events
	localparam int IRQ_W = 3;
	localparam int IRQ_RX = 0;
	localparam int IRQ_OVF = 1;
	localparam int IRQ_FLUSH = 2;

	// Pin synchroniser lanes and their reset levels
	localparam int PIN_W = 4;
	localparam int PIN_TCK = 0;
	localparam int PIN_TMS = 1;
	localparam int PIN_TDI = 2;
	localparam int PIN_TRST_N = 3;
	localparam logic [PIN_W-1:0] PIN_RST = 4'h8;

	// Test access port controller states
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} jdrp_tap_e;

endpackage

// >>> verilog/jdrp_rx_path.sv
`timescale 1ns/1ps
// Debugger-to-handler receive path behind the scan port
module jdrp_rx_path (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic i_trst_n,
	output logic o_tdo,
	output logic o_tdo_oe,
	input wire logic [jdrp_pkg::ADDR_W-1:0] i_addr,
	input wire logic [jdrp_pkg::WORD_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [jdrp_pkg::WORD_W-1:0] o_rdata,
	output logic o_irq
);

	typedef struct packed {
		jdrp_pkg::jdrp_tap_e tap;
		logic [jdrp_pkg::IR_W-1:0] ir;
		logic [jdrp_pkg::IR_W-1:0] ir_sr;
		logic [jdrp_pkg::SR_W-1:0] sr;
		logic bypass;
		logic [jdrp_pkg::HOLD_W-1:0] hold;
		logic tck_prev;
		logic tdo;
		logic tdo_oe;
		logic rdy;
		logic ovf;
		logic loop;
		logic [jdrp_pkg::WORD_W-1:0] rxbuf;
		logic [jdrp_pkg::IRQ_W-1:0] stat;
		logic [jdrp_pkg::IRQ_W-1:0] mask;
		logic [jdrp_pkg::WORD_W-1:0] rdata;
	} jdrp_state_s;

	jdrp_state_s st_q;
	jdrp_state_s st_d;
	logic [jdrp_pkg::PIN_W-1:0] pins;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic trst_s;
	logic tck_rise;
	logic tck_fall;
	logic rx_sel;
	logic upd_ev;
	logic wr_ev;
	logic rd_rx_ev;
	logic [jdrp_pkg::IRQ_W-1:0] ev;

	// TAP state advance on a sampled test clock rising edge
	function automatic jdrp_pkg::jdrp_tap_e tap_next(input jdrp_pkg::jdrp_tap_e s,
		input logic tms);
		jdrp_pkg::jdrp_tap_e n;
		n = s;
		case (s)
			jdrp_pkg::TAP_RESET: n = tms ? jdrp_pkg::TAP_RESET : jdrp_pkg::TAP_IDLE;
			jdrp_pkg::TAP_IDLE: n = tms ? jdrp_pkg::TAP_SEL_DR : jdrp_pkg::TAP_IDLE;
			jdrp_pkg::TAP_SEL_DR: n = tms ? jdrp_pkg::TAP_SEL_IR : jdrp_pkg::TAP_CAP_DR;
			jdrp_pkg::TAP_CAP_DR: n = tms ? jdrp_pkg::TAP_EXIT1_DR : jdrp_pkg::TAP_SHIFT_DR;
			jdrp_pkg::TAP_SHIFT_DR: n = tms ? jdrp_pkg::TAP_EXIT1_DR : jdrp_pkg::TAP_SHIFT_DR;
			jdrp_pkg::TAP_EXIT1_DR: n = tms ? jdrp_pkg::TAP_UPD_DR : jdrp_pkg::TAP_PAUSE_DR;
			jdrp_pkg::TAP_PAUSE_DR: n = tms ? jdrp_pkg::TAP_EXIT2_DR : jdrp_pkg::TAP_PAUSE_DR;
			jdrp_pkg::TAP_EXIT2_DR: n = tms ? jdrp_pkg::TAP_UPD_DR : jdrp_pkg::TAP_SHIFT_DR;
			jdrp_pkg::TAP_UPD_DR: n = tms ? jdrp_pkg::TAP_SEL_DR : jdrp_pkg::TAP_IDLE;
			jdrp_pkg::TAP_SEL_IR: n = tms ? jdrp_pkg::TAP_RESET : jdrp_pkg::TAP_CAP_IR;
			jdrp_pkg::TAP_CAP_IR: n = tms ? jdrp_pkg::TAP_EXIT1_IR : jdrp_pkg::TAP_SHIFT_IR;
			jdrp_pkg::TAP_SHIFT_IR: n = tms ? jdrp_pkg::TAP_EXIT1_IR : jdrp_pkg::TAP_SHIFT_IR;
			jdrp_pkg::TAP_EXIT1_IR: n = tms ? jdrp_pkg::TAP_UPD_IR : jdrp_pkg::TAP_PAUSE_IR;
			jdrp_pkg::TAP_PAUSE_IR: n = tms ? jdrp_pkg::TAP_EXIT2_IR : jdrp_pkg::TAP_PAUSE_IR;
			jdrp_pkg::TAP_EXIT2_IR: n = tms ? jdrp_pkg::TAP_UPD_IR : jdrp_pkg::TAP_SHIFT_IR;
			jdrp_pkg::TAP_UPD_IR: n = tms ? jdrp_pkg::TAP_SEL_DR : jdrp_pkg::TAP_IDLE;
			default: n = jdrp_pkg::TAP_RESET;
		endcase
		return n;
	endfunction

	// Bring the scan pins into the system clock domain
	jdrp_sync #(
		.W(jdrp_pkg::PIN_W),
		.RST_VAL(jdrp_pkg::PIN_RST)
	) u_pin_sync (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_async({i_trst_n, i_tdi, i_tms, i_tck}),
		.o_sync(pins)
	);

	// Decoded pin levels and test clock edges
	assign tck_s = pins[jdrp_pkg::PIN_TCK];
	assign tms_s = pins[jdrp_pkg::PIN_TMS];
	assign tdi_s = pins[jdrp_pkg::PIN_TDI];
	assign trst_s = ~pins[jdrp_pkg::PIN_TRST_N];
	assign tck_rise = tck_s & ~st_q.tck_prev;
	assign tck_fall = ~tck_s & st_q.tck_prev;
	assign rx_sel = (st_q.ir == jdrp_pkg::IR_RX_SELECT);
	assign upd_ev = tck_rise & rx_sel & ~trst_s & (st_q.tap == jdrp_pkg::TAP_UPD_DR);
	assign wr_ev = st_q.hold[jdrp_pkg::HOLD_VALID];
	assign rd_rx_ev = i_rd & (i_addr == jdrp_pkg::ADDR_RXBUF);

	// Next-state logic for scan port, write logic and handler registers
	always_comb
	begin
		st_d = st_q;
		ev = '0;
		st_d.tck_prev = tck_s;
		if (trst_s)
		begin
			st_d.tap = jdrp_pkg::TAP_RESET;
			st_d.ir = jdrp_pkg::IR_RESET_VAL;
			st_d.hold[jdrp_pkg::HOLD_VALID] = 1'b0;
			st_d.hold[jdrp_pkg::HOLD_FLUSH] = 1'b0;
			st_d.hold[jdrp_pkg::HOLD_LOOP] = 1'b0;
		end
		else if (tck_rise)
		begin
			st_d.tap = tap_next(st_q.tap, tms_s);
			case (st_q.tap)
				jdrp_pkg::TAP_RESET:
				begin
					st_d.ir = jdrp_pkg::IR_RESET_VAL;
				end
				jdrp_pkg::TAP_CAP_DR:
				begin
					st_d.sr = '0;
					st_d.bypass = 1'b0;
					st_d.sr[0] = st_q.rdy;
				end
				jdrp_pkg::TAP_SHIFT_DR:
				begin
					st_d.sr = {tdi_s, st_q.sr[jdrp_pkg::SR_W-1:1]};
					st_d.bypass = tdi_s;
				end
				jdrp_pkg::TAP_UPD_DR:
				begin
					if (rx_sel)
					begin
						st_d.hold = st_q.sr[jdrp_pkg::SR_W-1:1];
					end
				end
				jdrp_pkg::TAP_CAP_IR:
				begin
					st_d.ir_sr = jdrp_pkg::IR_CAPTURE_VAL;
				end
				jdrp_pkg::TAP_SHIFT_IR:
				begin
					st_d.ir_sr = {tdi_s, st_q.ir_sr[jdrp_pkg::IR_W-1:1]};
				end
				jdrp_pkg::TAP_UPD_IR:
				begin
					st_d.ir = st_q.ir_sr;
				end
				default:
				begin
					st_d.ir = st_q.ir;
				end
			endcase
		end
		// Data out changes on the falling test clock edge
		if (tck_fall)
		begin
			st_d.tdo_oe = (st_q.tap == jdrp_pkg::TAP_SHIFT_DR) ||
				(st_q.tap == jdrp_pkg::TAP_SHIFT_IR);
			if (st_q.tap == jdrp_pkg::TAP_SHIFT_IR)
			begin
				st_d.tdo = st_q.ir_sr[0];
			end
			else if (rx_sel)
			begin
				st_d.tdo = st_q.sr[0];
			end
			else
			begin
				st_d.tdo = st_q.bypass;
			end
		end
		// Handler read of the buffer consumes the word
		if (rd_rx_ev)
		begin
			st_d.rdy = 1'b0;
		end
		if (upd_ev)
		begin
			st_d.loop = st_q.sr[jdrp_pkg::HOLD_LOOP + 1];
			if (st_q.sr[jdrp_pkg::HOLD_FLUSH + 1])
			begin
				st_d.rdy = 1'b0;
				ev[jdrp_pkg::IRQ_FLUSH] = 1'b1;
			end
		end
		if (wr_ev)
		begin
			st_d.rxbuf = st_q.hold[jdrp_pkg::HOLD_WORD_HI:jdrp_pkg::HOLD_WORD_LO];
			if (!(upd_ev || trst_s))
			begin
				st_d.hold[jdrp_pkg::HOLD_VALID] = 1'b0;
			end
			if (st_q.rdy && !rd_rx_ev)
			begin
				st_d.ovf = 1'b1;
				ev[jdrp_pkg::IRQ_OVF] = 1'b1;
			end
			st_d.rdy = 1'b1;
			ev[jdrp_pkg::IRQ_RX] = 1'b1;
		end
		// Handler register writes; hardware sets win over clears
		if (i_wr && (i_addr == jdrp_pkg::ADDR_CTRL))
		begin
			st_d.ovf = (st_q.ovf & ~i_wdata[jdrp_pkg::CTRL_OVF]) | ev[jdrp_pkg::IRQ_OVF];
		end
		else if (i_wr && (i_addr == jdrp_pkg::ADDR_IRQ_MASK))
		begin
			st_d.mask = i_wdata[jdrp_pkg::IRQ_W-1:0];
		end
		if (i_wr && (i_addr == jdrp_pkg::ADDR_IRQ_STAT))
		begin
			st_d.stat = (st_q.stat & ~i_wdata[jdrp_pkg::IRQ_W-1:0]) | ev;
		end
		else
		begin
			st_d.stat = st_q.stat | ev;
		end
		// Read data stands in the cycle after the read strobe only
		st_d.rdata = '0;
		if (i_rd && (i_addr == jdrp_pkg::ADDR_CTRL))
		begin
			st_d.rdata[jdrp_pkg::CTRL_RDY] = st_q.rdy;
			st_d.rdata[jdrp_pkg::CTRL_OVF] = st_q.ovf;
			st_d.rdata[jdrp_pkg::CTRL_LOOP] = st_q.loop;
		end
		else if (rd_rx_ev)
		begin
			st_d.rdata = st_q.rxbuf;
		end
		else if (i_rd && (i_addr == jdrp_pkg::ADDR_IRQ_STAT))
		begin
			st_d.rdata[jdrp_pkg::IRQ_W-1:0] = st_q.stat;
		end
		else if (i_rd && (i_addr == jdrp_pkg::ADDR_IRQ_MASK))
		begin
			st_d.rdata[jdrp_pkg::IRQ_W-1:0] = st_q.mask;
		end
	end

	// State register; the processor reset keeps the holding register
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			st_q <= '0;
			st_q.tap <= jdrp_pkg::TAP_RESET;
			st_q.ir <= jdrp_pkg::IR_RESET_VAL;
			st_q.hold <= st_q.hold;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Outputs
	assign o_tdo = st_q.tdo;
	assign o_tdo_oe = st_q.tdo_oe;
	assign o_rdata = st_q.rdata;
	assign o_irq = |(st_q.stat & st_q.mask);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);

	a_capture_ready: assert property (tck_rise && !trst_s && rx_sel &&
		st_q.tap == jdrp_pkg::TAP_CAP_DR |=> st_q.sr[0] == $past(st_q.rdy))
		else $error("capture missed ready bit");
	a_shift_moves: assert property (tck_rise && !trst_s &&
		st_q.tap == jdrp_pkg::TAP_SHIFT_DR |=> st_q.sr ==
		{$past(tdi_s), $past(st_q.sr[jdrp_pkg::SR_W-1:1])})
		else $error("shift register did not shift");
	a_update_load: assert property (upd_ev |=>
		st_q.hold == $past(st_q.sr[jdrp_pkg::SR_W-1:1]))
		else $error("holding register not loaded");
	a_poll_no_write: assert property (!wr_ev |=> st_q.rxbuf == $past(st_q.rxbuf))
		else $error("buffer changed without valid");
	a_valid_cleared: assert property (wr_ev && !upd_ev |=>
		!st_q.hold[jdrp_pkg::HOLD_VALID])
		else $error("valid flag not cleared");
	a_ready_set: assert property (wr_ev |=> st_q.rdy && st_q.stat[jdrp_pkg::IRQ_RX])
		else $error("ready not set on write");
	a_overflow_set: assert property (wr_ev && st_q.rdy && !rd_rx_ev |=> st_q.ovf)
		else $error("overflow not flagged");
	a_word_commit: assert property (wr_ev |=> st_q.rxbuf ==
		$past(st_q.hold[jdrp_pkg::HOLD_WORD_HI:jdrp_pkg::HOLD_WORD_LO]))
		else $error("wrong word committed");
	a_loop_copy: assert property (upd_ev |=>
		st_q.loop == $past(st_q.sr[jdrp_pkg::HOLD_LOOP + 1]))
		else $error("loop flag not copied");
	a_flush_clear: assert property (upd_ev && st_q.sr[jdrp_pkg::HOLD_FLUSH + 1] &&
		!wr_ev |=> !st_q.rdy)
		else $error("flush left ready set");
	a_trst_clear: assert property (trst_s |=> !st_q.hold[jdrp_pkg::HOLD_VALID] &&
		!st_q.hold[jdrp_pkg::HOLD_FLUSH] && !st_q.hold[jdrp_pkg::HOLD_LOOP])
		else $error("test reset left flags set");
	a_proc_rst_keep: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		i_srst && !$past(i_srst) |=> st_q.hold == $past(st_q.hold) ##1
		(!$past(i_srst) || st_q.hold == $past(st_q.hold)))
		else $error("processor reset changed holding");

	c_word_written: cover property (upd_ev ##1 wr_ev ##1 st_q.rdy);
	c_overflow: cover property (wr_ev && st_q.rdy ##1 st_q.ovf);
	c_flush: cover property (upd_ev && st_q.sr[jdrp_pkg::HOLD_FLUSH + 1]);
	c_handler_read: cover property (st_q.rdy && rd_rx_ev ##1 !st_q.rdy);

endmodule

// >>> verilog/jdrp_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pins from outside the system clock
module jdrp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} jdrp_sync_s;

	jdrp_sync_s sync_q;
	jdrp_sync_s sync_d;

	// First stage feeds only the second stage
	always_comb
	begin
		sync_d.meta = i_async;
		sync_d.stable = sync_q.meta;
	end

	// Register both stages
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			sync_q <= {RST_VAL, RST_VAL};
		end
		else
		begin
			sync_q <= sync_d;
		end
	end

	assign o_sync = sync_q.stable;

endmodule
